// [hw/lcdcm_regs.sv]
// Display clock configuration and memory portal registers
`timescale 1ns/1ps
// Notes on behaviour
// [RL1] Portal access goes to sub-addressed byte
// [RL2] Every portal access advances the sub-address
// [RL3] Sub-address wraps 0Bh to 0, 1Bh to 10h
// [RL4] 00h-0Bh bank A, 10h-1Bh bank B
// [RL5] Portal is eight bits, resets to zero
// [RL6] Bit 7 picks peripheral or watch clock
// [RL7] Bits 6:4 prescale by powers of two
// [RL8] Bits 3:0 frame divider, 8 upward to 30
// [RL9] Blink divider codes 0-6 give 2-8, 7 gives 10
// [RL10] Higher blink codes step up to 64
// [RL11] Blink control applies at waveform end
// [RL12] Blink select ignored during bank alternation
// [RL13] Clock and blink registers reset zero, read/write
module lcdcm_regs
	import lcdcm_pkg::*;
(
	input  wire logic                  clock,          // 25 MHz clock
	input  wire logic                  arst_n,         // Async reset
	input  wire logic [BUS_ADDR_W-1:0] address,        // Byte address
	input  wire logic                  read,           // Read request
	input  wire logic                  write,          // Write request
	input  wire logic [31:0]           writedata,      // Write data
	input  wire logic [3:0]            byteenable,     // Byte lanes
	output logic      [31:0]           readdata,       // Read data
	output logic                       waitrequest,    // Stall
	input  wire logic                  watch_osc,      // Watch clock pin
	input  wire logic                  waveform_end,   // Frame pattern done
	input  wire logic                  bank_alternate, // Bank mode 1x
	input  wire logic [4:0]            disp_addr,      // Display byte addr
	output logic      [7:0]            disp_data,      // Display byte
	output logic                       clock_source_select, // 1: watch
	output logic                       frame_tick,     // Frame enable
	output logic                       blink_tick,     // Blink enable
	output logic      [1:0]            blink_select    // Active blink mode
);

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic [1:0] rst_sync_reg;
	logic       rst_n;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync_reg <= 2'b00;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	// ------------------------------------------------------------
	// Divider ratio tables
	// ------------------------------------------------------------
	function automatic logic [4:0] frame_ratio(input logic [3:0] code);
		logic [4:0] r;
		r = 5'h08;
		case (code)
			4'h0: r = 5'h08;
			4'h1: r = 5'h09;
			4'h2: r = 5'h0a;
			4'h3: r = 5'h0b;
			4'h4: r = 5'h0c;
			4'h5: r = 5'h0d;
			4'h6: r = 5'h0e;
			4'h7: r = 5'h0f;
			4'h8: r = 5'h10;
			4'h9: r = 5'h12;
			4'ha: r = 5'h14;
			4'hb: r = 5'h16;
			4'hc: r = 5'h18;
			4'hd: r = 5'h1a;
			4'he: r = 5'h1c;
			default: r = 5'h1e;
		endcase
		return r;
	endfunction : frame_ratio

	function automatic logic [6:0] blink_ratio(input logic [4:0] code);
		logic [6:0] r;
		r = 7'h02;
		if (code <= 5'h06) begin
			r = 7'({2'b00, code} + 7'h02); // RL9
		end else if (code == 5'h07) begin
			r = 7'h0a; // RL9
		end else if (code <= 5'h0c) begin
			r = 7'({code, 1'b0} - 7'h04); // RL10
		end else if (code <= 5'h0f) begin
			r = 7'({code, 2'b00} - 7'h1c); // RL10
		end else begin
			r = 7'({code, 1'b0} + 7'h02); // RL10
		end
		return r;
	endfunction : blink_ratio

	function automatic logic [4:0] next_sub(input logic [4:0] sa);
		logic [4:0] n;
		n = 5'(sa + 5'h01); // RL2
		if (sa == BANK_A_LAST) begin
			n = BANK_A_FIRST; // RL3
		end else if (sa == BANK_B_LAST) begin
			n = BANK_B_FIRST; // RL3
		end
		return n;
	endfunction : next_sub

	// ------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------
	lcdcm_bus_state_e bus_state_reg, bus_state_next;
	logic [7:0]       readdata_reg, readdata_next;
	logic [4:0]       sub_address_reg, sub_address_next;
	logic [7:0]       clock_config_reg, clock_config_next;
	logic [7:0]       blink_control_reg, blink_control_next;
	logic [7:0]       blink_active_reg, blink_active_next;
	logic [7:0]       mem_rd_data;
	logic             mem_we;
	logic [11:0]      reg_idx;
	logic             sel_sub, sel_portal, sel_clock, sel_blink;
	logic             sub_valid;
	logic             wr_lane;

	assign reg_idx    = address[BUS_ADDR_W-1:2];
	assign sub_valid  = (sub_address_reg[3:0] <= BANK_OFS_MAX); // RL4
	assign wr_lane    = write && byteenable[0];

	always_comb begin
		sel_sub    = 1'b0;
		sel_portal = 1'b0;
		sel_clock  = 1'b0;
		sel_blink  = 1'b0;
		if (reg_idx == SUB_ADDRESS_IDX) begin
			sel_sub = 1'b1;
		end else if (reg_idx == MEMORY_PORTAL_IDX) begin
			sel_portal = 1'b1;
		end else if (reg_idx == CLOCK_CONFIG_IDX) begin
			sel_clock = 1'b1;
		end else if (reg_idx == BLINK_CONTROL_IDX) begin
			sel_blink = 1'b1;
		end
	end

	// One fetch cycle lets the memory's registered read settle
	always_comb begin
		bus_state_next     = bus_state_reg;
		readdata_next      = readdata_reg;
		sub_address_next   = sub_address_reg;
		clock_config_next  = clock_config_reg;
		blink_control_next = blink_control_reg;
		mem_we             = 1'b0;
		case (bus_state_reg)
			LCDCM_BUS_IDLE: begin
				if (read || write) begin
					bus_state_next = LCDCM_BUS_FETCH;
				end
			end
			LCDCM_BUS_FETCH: begin
				bus_state_next = LCDCM_BUS_ACK;
				readdata_next  = 8'h00;
				if (sel_sub) begin
					readdata_next = {3'b000, sub_address_reg};
				end else if (sel_portal && sub_valid) begin
					readdata_next = mem_rd_data; // RL1
				end else if (sel_clock) begin
					readdata_next = clock_config_reg; // RL13
				end else if (sel_blink) begin
					readdata_next = blink_control_reg; // RL13
				end
			end
			LCDCM_BUS_ACK: begin
				bus_state_next = LCDCM_BUS_IDLE;
				if (sel_portal) begin
					sub_address_next = next_sub(sub_address_reg); // RL2
					mem_we = wr_lane && sub_valid; // RL1
				end
				if (wr_lane && sel_sub) begin
					sub_address_next = writedata[SUB_ADDRESS_W-1:0];
				end
				if (wr_lane && sel_clock) begin
					clock_config_next = writedata[7:0]; // RL13
				end
				if (wr_lane && sel_blink) begin
					blink_control_next = writedata[7:0]; // RL13
				end
			end
			default: begin
				bus_state_next = LCDCM_BUS_IDLE;
			end
		endcase
	end

	// Shadow copy reaches the display only at a frame boundary
	always_comb begin
		blink_active_next = blink_active_reg;
		if (waveform_end) begin
			blink_active_next = blink_control_reg; // RL11
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bus_state_reg     <= LCDCM_BUS_IDLE;
			readdata_reg      <= MEMORY_PORTAL_RST; // RL5
			sub_address_reg   <= SUB_ADDRESS_RST;
			clock_config_reg  <= CLOCK_CONFIG_RST; // RL13
			blink_control_reg <= BLINK_CONTROL_RST; // RL13
			blink_active_reg  <= BLINK_CONTROL_RST;
		end else begin
			bus_state_reg     <= bus_state_next;
			readdata_reg      <= readdata_next;
			sub_address_reg   <= sub_address_next;
			clock_config_reg  <= clock_config_next;
			blink_control_reg <= blink_control_next;
			blink_active_reg  <= blink_active_next;
		end
	end

	assign readdata    = {24'h000000, readdata_reg};
	assign waitrequest = (read || write) && (bus_state_reg != LCDCM_BUS_ACK);

	// ------------------------------------------------------------
	// Display memory
	// ------------------------------------------------------------
	lcdcm_bank_mem #(
		.DATA_W (8),
		.ADDR_W (SUB_ADDRESS_W)
	) u_mem (
		.clock     (clock),
		.rst_n     (rst_n),
		.wr_en     (mem_we),
		.wr_addr   (sub_address_reg),
		.wr_data   (writedata[7:0]), // RL5
		.rd_a_addr (sub_address_reg),
		.rd_a_data (mem_rd_data),
		.rd_b_addr (disp_addr),
		.rd_b_data (disp_data)
	);

	// ------------------------------------------------------------
	// Watch clock input
	// ------------------------------------------------------------
	logic [2:0] wto_sync_reg, wto_sync_next;
	logic       wto_level_reg, wto_level_next;
	logic       wto_rise;

	// Level only changes once the last two stages agree
	always_comb begin
		wto_sync_next  = {wto_sync_reg[1:0], watch_osc};
		wto_level_next = wto_level_reg;
		wto_rise       = 1'b0;
		if (wto_sync_reg[1] == wto_sync_reg[2]) begin
			wto_level_next = wto_sync_reg[2];
			wto_rise       = wto_sync_reg[2] && !wto_level_reg;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wto_sync_reg  <= 3'b000;
			wto_level_reg <= 1'b0;
		end else begin
			wto_sync_reg  <= wto_sync_next;
			wto_level_reg <= wto_level_next;
		end
	end

	// ------------------------------------------------------------
	// Prescaler, frame and blink dividers
	// ------------------------------------------------------------
	logic [4:0] pre_cnt_reg, pre_cnt_next;
	logic [4:0] frame_cnt_reg, frame_cnt_next;
	logic [6:0] blink_cnt_reg, blink_cnt_next;
	logic       frame_tick_reg, frame_tick_next;
	logic       blink_tick_reg, blink_tick_next;
	logic       src_tick, pre_tick;
	logic [4:0] pre_limit;
	logic [2:0] pre_code;
	logic [4:0] frame_lim;
	logic [6:0] blink_lim;

	assign pre_code  = clock_config_reg[PRESCALE_HI:PRESCALE_LO];
	assign frame_lim = 5'(frame_ratio(
		clock_config_reg[FRAME_DIV_HI:FRAME_DIV_LO]) - 5'h01); // RL8
	assign blink_lim = 7'(blink_ratio(
		blink_active_reg[BLINK_DIV_HI:BLINK_DIV_LO]) - 7'h01); // RL9

	always_comb begin
		// Peripheral clock ticks every cycle
		src_tick = clock_config_reg[CLK_SEL_BIT] ? wto_rise : 1'b1; // RL6
		// Reserved codes fall back to the slowest ratio
		pre_limit = PRESCALE_RSV_LIM;
		if (pre_code <= PRESCALE_MAX_CODE) begin
			pre_limit = 5'((6'h01 << pre_code) - 6'h01); // RL7
		end
	end

	// Counters compare with >= so a smaller ratio takes at once
	always_comb begin
		pre_cnt_next    = pre_cnt_reg;
		frame_cnt_next  = frame_cnt_reg;
		blink_cnt_next  = blink_cnt_reg;
		pre_tick        = 1'b0;
		frame_tick_next = 1'b0;
		blink_tick_next = 1'b0;
		if (src_tick) begin
			if (pre_cnt_reg >= pre_limit) begin
				pre_cnt_next = 5'h00;
				pre_tick     = 1'b1; // RL7
			end else begin
				pre_cnt_next = 5'(pre_cnt_reg + 5'h01);
			end
		end
		if (pre_tick) begin
			if (frame_cnt_reg >= frame_lim) begin
				frame_cnt_next  = 5'h00;
				frame_tick_next = 1'b1; // RL8
			end else begin
				frame_cnt_next = 5'(frame_cnt_reg + 5'h01);
			end
		end
		if (frame_tick_reg) begin
			if (blink_cnt_reg >= blink_lim) begin
				blink_cnt_next  = 7'h00;
				blink_tick_next = 1'b1; // RL10
			end else begin
				blink_cnt_next = 7'(blink_cnt_reg + 7'h01);
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pre_cnt_reg    <= 5'h00;
			frame_cnt_reg  <= 5'h00;
			blink_cnt_reg  <= 7'h00;
			frame_tick_reg <= 1'b0;
			blink_tick_reg <= 1'b0;
		end else begin
			pre_cnt_reg    <= pre_cnt_next;
			frame_cnt_reg  <= frame_cnt_next;
			blink_cnt_reg  <= blink_cnt_next;
			frame_tick_reg <= frame_tick_next;
			blink_tick_reg <= blink_tick_next;
		end
	end

	// ------------------------------------------------------------
	// Outputs to the waveform side
	// ------------------------------------------------------------
	assign clock_source_select = clock_config_reg[CLK_SEL_BIT]; // RL6
	assign frame_tick          = frame_tick_reg;
	assign blink_tick          = blink_tick_reg;
	// Alternating banks owns the display, so blinking is muted
	assign blink_select = bank_alternate ? 2'b00 :
		blink_active_reg[BLINK_SEL_HI:BLINK_SEL_LO]; // RL12

endmodule : lcdcm_regs

// [common/lcdcm_pkg.sv]
// Constants shared by the display clock and memory portal register block
package lcdcm_pkg;

	// ------------------------------------------------------------
	// Register indices; byte address is four times the index
	// ------------------------------------------------------------
	localparam int         BUS_ADDR_W        = 14;
	localparam logic [11:0] SUB_ADDRESS_IDX  = 12'hfb1;
	localparam logic [11:0] MEMORY_PORTAL_IDX = 12'hfb2;
	localparam logic [11:0] CLOCK_CONFIG_IDX = 12'hfb3;
	localparam logic [11:0] BLINK_CONTROL_IDX = 12'hfb4;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [4:0] SUB_ADDRESS_RST   = 5'h00;
	localparam logic [7:0] MEMORY_PORTAL_RST = 8'h00;
	localparam logic [7:0] CLOCK_CONFIG_RST  = 8'h00;
	localparam logic [7:0] BLINK_CONTROL_RST = 8'h00;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int SUB_ADDRESS_W   = 5;
	localparam int CLK_SEL_BIT     = 7;
	localparam int PRESCALE_HI     = 6;
	localparam int PRESCALE_LO     = 4;
	localparam int FRAME_DIV_HI    = 3;
	localparam int FRAME_DIV_LO    = 0;
	localparam int BLINK_DIV_HI    = 7;
	localparam int BLINK_DIV_LO    = 3;
	localparam int BLINK_SEL_HI    = 2;
	localparam int BLINK_SEL_LO    = 1;
	localparam int BANK_ALT_BIT    = 1;

	// ------------------------------------------------------------
	// Sub-address map and wrap points
	// ------------------------------------------------------------
	localparam logic [4:0] BANK_A_FIRST = 5'h00;
	localparam logic [4:0] BANK_A_LAST  = 5'h0b;
	localparam logic [4:0] BANK_B_FIRST = 5'h10;
	localparam logic [4:0] BANK_B_LAST  = 5'h1b;
	localparam logic [3:0] BANK_OFS_MAX = 4'hb;

	// ------------------------------------------------------------
	// Divider limits
	// ------------------------------------------------------------
	localparam logic [2:0] PRESCALE_MAX_CODE = 3'h5;
	localparam logic [4:0] PRESCALE_RSV_LIM  = 5'h1f;

	typedef enum logic [1:0] {
		LCDCM_BUS_IDLE,
		LCDCM_BUS_FETCH,
		LCDCM_BUS_ACK
	} lcdcm_bus_state_e;

endpackage : lcdcm_pkg

// [hw/lcdcm_bank_mem.sv]
// Display memory for both banks with one write and two read ports
`timescale 1ns/1ps
module lcdcm_bank_mem #(
	parameter int DATA_W = 8,
	parameter int ADDR_W = 5
) (
	input  wire logic              clock,     // System clock
	input  wire logic              rst_n,     // Synchronised reset
	input  wire logic              wr_en,     // Write strobe
	input  wire logic [ADDR_W-1:0] wr_addr,   // Write address
	input  wire logic [DATA_W-1:0] wr_data,   // Write data
	input  wire logic [ADDR_W-1:0] rd_a_addr, // Software read address
	output logic      [DATA_W-1:0] rd_a_data, // Software read data
	input  wire logic [ADDR_W-1:0] rd_b_addr, // Display read address
	output logic      [DATA_W-1:0] rd_b_data  // Display read data
);

	logic [DATA_W-1:0] mem [2**ADDR_W];

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	// Cleared at reset so a portal read before any write gives zero
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 2**ADDR_W; i++) begin
				mem[i] <= '0;
			end
		end else if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// ------------------------------------------------------------
	// Registered read ports
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rd_a_data <= '0;
			rd_b_data <= '0;
		end else begin
			rd_a_data <= mem[rd_a_addr];
			rd_b_data <= mem[rd_b_addr];
		end
	end

endmodule : lcdcm_bank_mem

// [verification/lcdcm_regs_sva.sv]
// Concurrent checks on the display clock and memory portal registers
`timescale 1ns/1ps
module lcdcm_regs_sva
	import lcdcm_pkg::*;
(
	input wire logic                  clock,               // Clock
	input wire logic                  arst_n,              // Reset
	input wire logic [BUS_ADDR_W-1:0] address,             // Address
	input wire logic                  read,                // Read
	input wire logic                  write,               // Write
	input wire logic [31:0]           writedata,           // Wr data
	input wire logic [3:0]            byteenable,          // Lanes
	input wire logic [31:0]           readdata,            // Rd data
	input wire logic                  waitrequest,         // Stall
	input wire logic                  waveform_end,        // Frame end
	input wire logic                  bank_alternate,      // Bank mode
	input wire logic                  clock_source_select, // Source
	input wire logic                  frame_tick,          // Frame
	input wire logic                  blink_tick,          // Blink
	input wire logic [1:0]            blink_select         // Mode
);
	// ------------------------------------------------------------
	// Shadow of sub-address and clock config
	// ------------------------------------------------------------
	logic [4:0]  sub_reg;
	logic [4:0]  sub_next;
	logic [7:0]  cfg_reg;
	logic [7:0]  cfg_next;
	logic [11:0] idx;
	logic        done;
	logic        wr_ok;
	assign idx   = address[13:2];
	assign done  = (read | write) & ~waitrequest;
	assign wr_ok = done & write & byteenable[0];
	always_comb begin
		sub_next = sub_reg;
		cfg_next = cfg_reg;
		if (wr_ok && idx == SUB_ADDRESS_IDX)
			sub_next = writedata[4:0];
		if (done && idx == MEMORY_PORTAL_IDX)
			sub_next = (sub_reg == BANK_A_LAST) ? BANK_A_FIRST :
				(sub_reg == BANK_B_LAST) ? BANK_B_FIRST : sub_reg + 5'h01;
		if (wr_ok && idx == CLOCK_CONFIG_IDX)
			cfg_next = writedata[7:0];
	end
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sub_reg <= 5'h00;
			cfg_reg <= 8'h00;
		end else begin
			sub_reg <= sub_next;
			cfg_reg <= cfg_next;
		end
	end
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!arst_n);
	sequence req_start;
		$rose(read | write);
	endsequence
	sequence two_waits;
		waitrequest ##1 waitrequest ##1 !waitrequest;
	endsequence
	bus_answer_a: assert property (req_start |-> two_waits)
		else $error("bus answer not after two wait cycles");
	idle_no_stall_a: assert property (
		!(read | write) |-> !waitrequest)
		else $error("stall without a request");
	sub_advance_a: assert property (
		done && read && idx == SUB_ADDRESS_IDX |->
		readdata == {27'h0, sub_reg})
		else $error("sub-address did not advance or wrap");
	read_upper_a: assert property (
		done && read |-> readdata[31:8] == 24'h0)
		else $error("read data upper bytes not zero");
	cfg_read_a: assert property (
		done && read && idx == CLOCK_CONFIG_IDX |->
		readdata == {24'h0, cfg_reg})
		else $error("clock config readback wrong");
	clk_src_a: assert property (clock_source_select == cfg_reg[7])
		else $error("clock source select not from config bit 7");
	blink_hold_a: assert property (
		$changed(blink_select) |-> $past(waveform_end) ||
		bank_alternate || $past(bank_alternate) || $past(bank_alternate, 2))
		else $error("blink select changed outside frame end");
	alt_force_a: assert property (
		bank_alternate && $past(bank_alternate) |-> blink_select == 2'b00)
		else $error("blink select not cleared in bank alternation");
	frame_gap_a: assert property (frame_tick |=> !frame_tick[*7])
		else $error("frame ticks closer than eight cycles");
	blink_gap_a: assert property (blink_tick |=> !blink_tick[*8])
		else $error("blink ticks too close");
endmodule : lcdcm_regs_sva

bind lcdcm_regs lcdcm_regs_sva u_sva (
	.clock(clock),
	.arst_n(arst_n),
	.address(address),
	.read(read),
	.write(write),
	.writedata(writedata),
	.byteenable(byteenable),
	.readdata(readdata),
	.waitrequest(waitrequest),
	.waveform_end(waveform_end),
	.bank_alternate(bank_alternate),
	.clock_source_select(clock_source_select),
	.frame_tick(frame_tick),
	.blink_tick(blink_tick),
	.blink_select(blink_select)
);

// [verification/lcdcm_regs_tb_top.sv]
// Self-checking bench for the display clock and memory portal registers
`timescale 1ns/1ps
module lcdcm_regs_tb_top
	import lcdcm_pkg::*;
;
	logic                  clock, arst_n, read, write, waitrequest;
	logic                  waveform_end, bank_alternate;
	logic                  watch_osc = 1'b0;
	logic                  clock_source_select, frame_tick, blink_tick;
	logic [BUS_ADDR_W-1:0] address;
	logic [31:0]           writedata, readdata, rd;
	logic [3:0]            byteenable;
	logic [4:0]            disp_addr;
	logic [7:0]            disp_data;
	logic [1:0]            blink_select;
	int                    miscompares, checks_done, cyc;
	int                    wcnt = 0;
	logic [4:0]            sa [5] = '{5'h0a, 5'h0b, 5'h00, 5'h1b, 5'h10};
	logic [7:0]            dv [5] = '{8'hc3, 8'hff, 8'h3c, 8'h81, 8'h7e};
	logic [7:0]            cfg [6] = '{8'h00, 8'h15, 8'h5f, 8'h2f, 8'h80,
		8'h60};
	int                    fper [6] = '{8, 26, 960, 120, 80, 256};
	logic [4:0]            bdv [4] = '{5'h00, 5'h06, 5'h0f, 5'h1f};
	int                    bper [4] = '{16, 64, 256, 512};

	lcdcm_regs dut (
		.clock(clock),
		.arst_n(arst_n),
		.address(address),
		.read(read),
		.write(write),
		.writedata(writedata),
		.byteenable(byteenable),
		.readdata(readdata),
		.waitrequest(waitrequest),
		.watch_osc(watch_osc),
		.waveform_end(waveform_end),
		.bank_alternate(bank_alternate),
		.disp_addr(disp_addr),
		.disp_data(disp_data),
		.clock_source_select(clock_source_select),
		.frame_tick(frame_tick),
		.blink_tick(blink_tick),
		.blink_select(blink_select)
	);

	// ------------------------------------------------------------
	// Clock, watch oscillator and watchdog
	// ------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// Slow source, ten cycles a period, keeps the frame test short
	always @(posedge clock) begin
		wcnt <= (wcnt == 4) ? 0 : wcnt + 1;
		if (wcnt == 4)
			watch_osc <= ~watch_osc;
	end
	initial begin
		#2000000;
		miscompares++;
		end_of_test();
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp,
			input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Holds the request until waitrequest is seen low; a hang is the
	// watchdog's to end
	task automatic bus(input logic wr, input logic [11:0] idx,
			input logic [7:0] d);
		address   <= {idx, 2'b00};
		writedata <= {24'h0, d};
		read      <= ~wr;
		write     <= wr;
		do begin
			@(posedge clock);
		end while (waitrequest !== 1'b0);
		rd = readdata;
		read  <= 1'b0;
		write <= 1'b0;
		@(posedge clock);
	endtask : bus

	// Second interval is tick to tick; the first only finds a tick
	task automatic period(input logic blink, output int n);
		repeat (2) begin
			n = 0;
			do begin
				@(negedge clock);
				n++;
			end while ((blink ? blink_tick : frame_tick) !== 1'b1 && n < 9000);
		end
		@(posedge clock);
	endtask : period

	task automatic pulse_end();
		waveform_end <= 1'b1;
		@(posedge clock);
		waveform_end <= 1'b0;
		repeat (2) @(posedge clock);
	endtask : pulse_end

	task automatic end_of_test();
		$display("Checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		{arst_n, read, write, waveform_end, bank_alternate} = 5'h00;
		{address, writedata, disp_addr} = 0;
		byteenable = 4'h1;
		miscompares = 0;
		checks_done = 0;
		repeat (4) @(posedge clock);
		arst_n <= 1'b1;
		repeat (4) @(posedge clock);
		bus(1'b0, CLOCK_CONFIG_IDX, 8'h00);
		chk("clock_config", 32'h0, rd);
		bus(1'b0, BLINK_CONTROL_IDX, 8'h00);
		chk("blink_control", 32'h0, rd);
		bus(1'b0, MEMORY_PORTAL_IDX, 8'h00);
		chk("memory_portal", 32'h0, rd);
		bus(1'b0, 12'h000, 8'h00);
		chk("unmapped", 32'h0, rd);
		$display("reset test done");
		bus(1'b1, SUB_ADDRESS_IDX, sa[0]);
		for (int i = 0; i < 3; i++)
			bus(1'b1, MEMORY_PORTAL_IDX, dv[i]);
		bus(1'b0, SUB_ADDRESS_IDX, 8'h00);
		chk("sub_address", 32'h01, rd);
		bus(1'b1, SUB_ADDRESS_IDX, sa[3]);
		for (int i = 3; i < 5; i++)
			bus(1'b1, MEMORY_PORTAL_IDX, dv[i]);
		bus(1'b0, SUB_ADDRESS_IDX, 8'h00);
		chk("sub_address", 32'h11, rd);
		for (int i = 0; i < 5; i++) begin
			if (i == 0 || i == 3)
				bus(1'b1, SUB_ADDRESS_IDX, sa[i]);
			bus(1'b0, MEMORY_PORTAL_IDX, 8'h00);
			chk("portal_read", 32'(dv[i]), rd);
			disp_addr <= sa[i];
			repeat (2) @(posedge clock);
			chk("display_byte", 32'(dv[i]), 32'(disp_data));
		end
		bus(1'b1, SUB_ADDRESS_IDX, 8'h0c);
		bus(1'b1, MEMORY_PORTAL_IDX, 8'h55);
		bus(1'b0, SUB_ADDRESS_IDX, 8'h00);
		chk("sub_address", 32'h0d, rd);
		bus(1'b1, SUB_ADDRESS_IDX, 8'h0c);
		bus(1'b0, MEMORY_PORTAL_IDX, 8'h00);
		chk("reserved_byte", 32'h0, rd);
		byteenable <= 4'h0;
		bus(1'b1, CLOCK_CONFIG_IDX, 8'hff);
		byteenable <= 4'h1;
		bus(1'b0, CLOCK_CONFIG_IDX, 8'h00);
		chk("lane_write", 32'h0, rd);
		$display("portal test done");
		for (int i = 0; i < 6; i++) begin
			bus(1'b1, CLOCK_CONFIG_IDX, cfg[i]);
			bus(1'b0, CLOCK_CONFIG_IDX, 8'h00);
			chk("clock_config", 32'(cfg[i]), rd);
			chk("source", 32'(cfg[i][7]), 32'(clock_source_select));
			period(1'b0, cyc);
			chk("frame_period", 32'(fper[i]), 32'(cyc));
		end
		bus(1'b1, CLOCK_CONFIG_IDX, 8'h00);
		$display("clock test done");
		bus(1'b1, BLINK_CONTROL_IDX, 8'h3e);
		chk("blink_select", 32'h0, 32'(blink_select));
		bus(1'b0, BLINK_CONTROL_IDX, 8'h00);
		chk("blink_control", 32'h3e, rd);
		pulse_end();
		chk("blink_select", 32'h3, 32'(blink_select));
		period(1'b1, cyc);
		chk("blink_period", 32'd80, 32'(cyc));
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, BLINK_CONTROL_IDX, {bdv[i], 3'b010});
			pulse_end();
			period(1'b1, cyc);
			chk("blink_period", 32'(bper[i]), 32'(cyc));
		end
		bank_alternate <= 1'b1;
		repeat (2) @(posedge clock);
		chk("blink_select", 32'h0, 32'(blink_select));
		bank_alternate <= 1'b0;
		repeat (2) @(posedge clock);
		chk("blink_select", 32'h1, 32'(blink_select));
		$display("blink test done");
		end_of_test();
	end
endmodule : lcdcm_regs_tb_top
